// ==== hdl/fpwb_top.sv ====
//
// Contract
// - erase and write act on 128-word pages, read moves one word
// - write buffer holds 128 sixteen-bit words, one page
// - enabled flag goes high when enable procedure succeeds
// - buffer accepts data only while enabled flag is high
// - write start bit set by firmware, cleared when write completes
// - reads are inhibited while read enable bit is low
// - read start bit does one-word read, clears when done
// - address bits 15..7 pick page 0..511, low seven pick word
// - buffer clear bit clears buffer then returns to zero
// - high-byte write loads high plus stored low byte into buffer
// - each buffer load below offset 1111111b increments the word offset (address bits 6..0) by one
// - word offset saturates at 1111111b
// - buffer clears itself when a page write finishes
// - mode 000 write, 001 erase, 011 read, 110 enable, rest reserved
// - trigger bit starts timer, cleared by hardware on expiry
// - low-byte write only updates its register
// - software cannot set enabled flag, only clear it
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "fpwb_consts.svh"
module fpwb_top #(
   parameter int PAGE_WORDS = 128,
   parameter int OFS_W = 7,
   parameter int ENABLE_WIN_CYC = 2048,
   parameter int CLEAR_CYC = 8
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire fpwb_pkg::fpwb_bus_s bus_i,
   output logic [7:0] rdata_o,
   output fpwb_pkg::fpwb_flash_cmd_s flash_cmd_o,
   output logic [15:0] flash_wdata_o,
   input wire logic flash_done_i,
   input wire logic [15:0] flash_rdata_i,
   input wire logic [OFS_W-1:0] buf_raddr_i,
   output logic [15:0] buf_rdata_o,
   output logic ewen_flag_o
);
   import fpwb_pkg::*;
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      fpwb_state_e st;
      logic ewen;
      logic [2:0] mode;
      logic trig;
      logic wst;
      logic ren;
      logic rst_bit;
      logic [7:0] ctrl1;
      logic tsel;
      logic clr;
      logic [15:0] faddr;
      logic [7:0] d0l;
      logic [7:0] d0h;
      logic [15:0] d1;
      logic [15:0] d2;
      logic [15:0] d3;
      logic [15:0] win_cnt;
      logic [15:0] clr_cnt;
      logic [7:0] rdata;
      fpwb_flash_cmd_s cmd;
      logic buf_clr;
      logic buf_wr;
      logic [OFS_W-1:0] buf_waddr;
      logic [15:0] buf_wdata;
   } fpwb_state_s;
   fpwb_state_s s_reg;
   fpwb_state_s s_next;
   logic wr_c0;
   logic wr_c2;
   logic load_hi;
   // ----------------------------------------
   // write buffer
   // ----------------------------------------
   fpwb_buffer #(
      .WORDS(PAGE_WORDS),
      .AW(OFS_W)
   ) u_buf (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .clear_i(s_reg.buf_clr),
      .wr_i(s_reg.buf_wr),
      .waddr_i(s_reg.buf_waddr),
      .wdata_i(s_reg.buf_wdata),
      .raddr_i(buf_raddr_i),
      .rdata_o(buf_rdata_o)
   );
   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      s_next = s_reg;
      s_next.buf_clr = 1'b0;
      s_next.buf_wr = 1'b0;
      s_next.cmd.req = 1'b0;
      wr_c0 = bus_i.wr && bus_i.addr == `FPWB_ADDR_CTRL0;
      wr_c2 = bus_i.wr && bus_i.addr == `FPWB_ADDR_CTRL2;
      load_hi = bus_i.wr && bus_i.addr == `FPWB_ADDR_D0H && s_reg.ewen;
      // register writes
      if (bus_i.wr) begin
         case (bus_i.addr)
            `FPWB_ADDR_CTRL1: s_next.ctrl1 = bus_i.wdata;
            `FPWB_ADDR_ALO: s_next.faddr[7:0] = bus_i.wdata;
            `FPWB_ADDR_AHI: s_next.faddr[15:8] = bus_i.wdata;
            `FPWB_ADDR_D0L: s_next.d0l = bus_i.wdata;
            `FPWB_ADDR_D0H: s_next.d0h = bus_i.wdata;
            `FPWB_ADDR_D1L: s_next.d1[7:0] = bus_i.wdata;
            `FPWB_ADDR_D1H: s_next.d1[15:8] = bus_i.wdata;
            `FPWB_ADDR_D2L: s_next.d2[7:0] = bus_i.wdata;
            `FPWB_ADDR_D2H: s_next.d2[15:8] = bus_i.wdata;
            `FPWB_ADDR_D3L: s_next.d3[7:0] = bus_i.wdata;
            `FPWB_ADDR_D3H: s_next.d3[15:8] = bus_i.wdata;
            default: ;
         endcase
      end
      if (wr_c0) begin
         s_next.mode = bus_i.wdata[`FPWB_C0_MODE_HI:`FPWB_C0_MODE_LO];
         s_next.ren = bus_i.wdata[`FPWB_C0_REN];
         // writing one to the flag does nothing, zero disables
         if (!bus_i.wdata[`FPWB_C0_EWEN]) begin
            s_next.ewen = 1'b0;
         end
         // start bits are only set by software; busy bits hold otherwise
         if (bus_i.wdata[`FPWB_C0_TRIG]) begin
            s_next.trig = 1'b1;
            s_next.win_cnt = `FPWB_WORD_ZERO;
         end
         if (bus_i.wdata[`FPWB_C0_WST]) begin
            s_next.wst = 1'b1;
         end
         if (bus_i.wdata[`FPWB_C0_RST]) begin
            s_next.rst_bit = 1'b1;
         end
      end
      if (wr_c2) begin
         s_next.tsel = bus_i.wdata[`FPWB_C2_TSEL];
         if (bus_i.wdata[`FPWB_C2_CLR]) begin
            s_next.clr = 1'b1;
         end
      end
      // ----------------------------------------
      // enable procedure window
      // ----------------------------------------
      if (s_reg.trig) begin
         if (s_reg.mode == `FPWB_MODE_EWEN && s_reg.d1 == `FPWB_UNLOCK1 && s_reg.d2 == `FPWB_UNLOCK2
               && s_reg.d3 == `FPWB_UNLOCK3) begin
            s_next.ewen = 1'b1;
            s_next.trig = 1'b0;
         end else if (s_reg.win_cnt == 16'(ENABLE_WIN_CYC - 1)) begin
            s_next.trig = 1'b0;
         end else begin
            s_next.win_cnt = s_reg.win_cnt + `FPWB_CNT_ONE;
         end
      end
      // ----------------------------------------
      // buffer load
      // ----------------------------------------
      if (load_hi) begin
         s_next.buf_wr = 1'b1;
         s_next.buf_waddr = s_reg.faddr[OFS_W-1:0];
         s_next.buf_wdata = {bus_i.wdata, s_reg.d0l};
         if (s_reg.faddr[OFS_W-1:0] != `FPWB_OFS_LAST) begin
            s_next.faddr[OFS_W-1:0] = s_reg.faddr[OFS_W-1:0] + `FPWB_OFS_ONE;
         end
      end
      // ----------------------------------------
      // sequencer
      // ----------------------------------------
      case (s_reg.st)
         FPWB_IDLE: begin
            if (s_reg.clr) begin
               s_next.buf_clr = 1'b1;
               // own counter, so a clear cannot stretch the enable window
               s_next.clr_cnt = `FPWB_WORD_ZERO;
               s_next.st = FPWB_CLEAR;
            end else if (s_reg.wst) begin
               // write or erase needs the enable; reserved codes just finish
               if (s_reg.ewen && (s_reg.mode == `FPWB_MODE_WRITE || s_reg.mode == `FPWB_MODE_ERASE)) begin
                  s_next.cmd.req = 1'b1;
                  s_next.cmd.mode = s_reg.mode;
                  s_next.cmd.addr = {s_reg.faddr[15:OFS_W], {OFS_W{1'b0}}};
                  s_next.st = FPWB_BUSY;
               end else begin
                  s_next.wst = 1'b0;
               end
            end else if (s_reg.rst_bit) begin
               if (s_reg.ren && s_reg.mode == `FPWB_MODE_READ) begin
                  s_next.cmd.req = 1'b1;
                  s_next.cmd.mode = s_reg.mode;
                  s_next.cmd.addr = s_reg.faddr;
                  s_next.st = FPWB_READ;
               end else begin
                  s_next.rst_bit = 1'b0;
               end
            end
         end
         FPWB_CLEAR: begin
            // clear is held a few cycles so the bit reads as busy
            if (s_reg.clr_cnt == 16'(CLEAR_CYC - 1)) begin
               s_next.clr = 1'b0;
               s_next.st = FPWB_IDLE;
            end else begin
               s_next.buf_clr = 1'b1;
               s_next.clr_cnt = s_reg.clr_cnt + `FPWB_CNT_ONE;
            end
         end
         FPWB_BUSY: begin
            if (flash_done_i) begin
               s_next.wst = 1'b0;
               if (s_reg.cmd.mode == `FPWB_MODE_WRITE) begin
                  s_next.buf_clr = 1'b1;
               end
               s_next.st = FPWB_IDLE;
            end
         end
         FPWB_READ: begin
            if (flash_done_i) begin
               s_next.d0l = flash_rdata_i[7:0];
               s_next.d0h = flash_rdata_i[15:8];
               s_next.rst_bit = 1'b0;
               s_next.st = FPWB_IDLE;
            end
         end
         default: s_next.st = FPWB_IDLE;
      endcase
      // ----------------------------------------
      // read data, one cycle after strobe
      // ----------------------------------------
      s_next.rdata = `FPWB_BYTE_ZERO;
      if (bus_i.rd) begin
         case (bus_i.addr)
            `FPWB_ADDR_CTRL0: s_next.rdata = {s_reg.ewen, s_reg.mode, s_reg.trig, s_reg.wst, s_reg.ren,
                                              s_reg.rst_bit};
            `FPWB_ADDR_CTRL1: s_next.rdata = s_reg.ctrl1;
            `FPWB_ADDR_CTRL2: s_next.rdata = {6'h00, s_reg.tsel, s_reg.clr};
            `FPWB_ADDR_ALO: s_next.rdata = s_reg.faddr[7:0];
            `FPWB_ADDR_AHI: s_next.rdata = s_reg.faddr[15:8];
            `FPWB_ADDR_D0L: s_next.rdata = s_reg.d0l;
            `FPWB_ADDR_D0H: s_next.rdata = s_reg.d0h;
            `FPWB_ADDR_D1L: s_next.rdata = s_reg.d1[7:0];
            `FPWB_ADDR_D1H: s_next.rdata = s_reg.d1[15:8];
            `FPWB_ADDR_D2L: s_next.rdata = s_reg.d2[7:0];
            `FPWB_ADDR_D2H: s_next.rdata = s_reg.d2[15:8];
            `FPWB_ADDR_D3L: s_next.rdata = s_reg.d3[7:0];
            `FPWB_ADDR_D3H: s_next.rdata = s_reg.d3[15:8];
            default: s_next.rdata = `FPWB_BYTE_ZERO;
         endcase
      end
   end
   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end
   assign rdata_o = s_reg.rdata;
   assign flash_cmd_o = s_reg.cmd;
   assign flash_wdata_o = s_reg.buf_wdata;
   assign ewen_flag_o = s_reg.ewen;
endmodule : fpwb_top

// ==== hdl/fpwb_consts.svh ====
`ifndef FPWB_CONSTS_SVH
`define FPWB_CONSTS_SVH
// ----------------------------------------
// register addresses
// ----------------------------------------
`define FPWB_ADDR_CTRL0 4'h0
`define FPWB_ADDR_CTRL1 4'h1
`define FPWB_ADDR_CTRL2 4'h2
`define FPWB_ADDR_ALO 4'h3
`define FPWB_ADDR_AHI 4'h4
`define FPWB_ADDR_D0L 4'h5
`define FPWB_ADDR_D0H 4'h6
`define FPWB_ADDR_D1L 4'h7
`define FPWB_ADDR_D1H 4'h8
`define FPWB_ADDR_D2L 4'h9
`define FPWB_ADDR_D2H 4'hA
`define FPWB_ADDR_D3L 4'hB
`define FPWB_ADDR_D3H 4'hC
// ----------------------------------------
// control0 and control2 bit positions
// ----------------------------------------
`define FPWB_C0_EWEN 7
`define FPWB_C0_MODE_HI 6
`define FPWB_C0_MODE_LO 4
`define FPWB_C0_TRIG 3
`define FPWB_C0_WST 2
`define FPWB_C0_REN 1
`define FPWB_C0_RST 0
`define FPWB_C2_CLR 0
`define FPWB_C2_TSEL 1
// ----------------------------------------
// mode codes
// ----------------------------------------
`define FPWB_MODE_WRITE 3'h0
`define FPWB_MODE_ERASE 3'h1
`define FPWB_MODE_READ 3'h3
`define FPWB_MODE_EWEN 3'h6
// ----------------------------------------
// reset values and misc
// ----------------------------------------
`define FPWB_BYTE_ZERO 8'h00
`define FPWB_WORD_ZERO 16'h0000
`define FPWB_OFS_LAST 7'h7F
`define FPWB_OFS_ONE 7'h01
`define FPWB_CNT_ONE 16'h0001
`define FPWB_UNLOCK1 16'h0001
`define FPWB_UNLOCK2 16'h0002
`define FPWB_UNLOCK3 16'h0003
`endif

// ==== hdl/fpwb_pkg.sv ====
package fpwb_pkg;
   typedef enum logic [2:0] {
      FPWB_IDLE = 3'h0,
      FPWB_CLEAR = 3'h1,
      FPWB_BUSY = 3'h3,
      FPWB_READ = 3'h2
   } fpwb_state_e;
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } fpwb_bus_s;
   typedef struct packed {
      logic req;
      logic [2:0] mode;
      logic [15:0] addr;
   } fpwb_flash_cmd_s;
endpackage : fpwb_pkg

// ==== hdl/fpwb_buffer.sv ====
`timescale 1ns/1ps
`include "fpwb_consts.svh"
// ----------------------------------------
// page write buffer, one word per entry
// ----------------------------------------
module fpwb_buffer #(
   parameter int WORDS = 128,
   parameter int AW = 7
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic clear_i,
   input wire logic wr_i,
   input wire logic [AW-1:0] waddr_i,
   input wire logic [15:0] wdata_i,
   input wire logic [AW-1:0] raddr_i,
   output logic [15:0] rdata_o
);
   logic [15:0] mem_reg [WORDS];
   logic [15:0] rdata_reg;
   // reset and clear wipe every entry, hence per-entry registers
   for (genvar i = 0; i < WORDS; i++) begin : g_word
      always_ff @(posedge clk_sys_i) begin
         if (rst_i || clear_i) begin
            mem_reg[i] <= `FPWB_WORD_ZERO;
         end else if (wr_i && waddr_i == AW'(i)) begin
            mem_reg[i] <= wdata_i;
         end
      end
   end
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         rdata_reg <= `FPWB_WORD_ZERO;
      end else begin
         rdata_reg <= mem_reg[raddr_i];
      end
   end
   assign rdata_o = rdata_reg;
endmodule : fpwb_buffer

// ==== dv/fpwb_checker.sv ====
`timescale 1ns/1ps
`include "fpwb_consts.svh"
module fpwb_checker (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire fpwb_pkg::fpwb_bus_s bus_i,
   input wire fpwb_pkg::fpwb_flash_cmd_s flash_cmd_o,
   input wire logic [15:0] flash_wdata_o,
   input wire logic ewen_flag_o
);
   import fpwb_pkg::*;
   // ------
   // port relations
   // ------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   logic hi_wr;
   logic c0_wr;
   assign hi_wr = bus_i.wr && bus_i.addr == `FPWB_ADDR_D0H;
   assign c0_wr = bus_i.wr && bus_i.addr == `FPWB_ADDR_CTRL0;
   property p_load;
      ewen_flag_o && hi_wr |=> flash_wdata_o[15:8] == $past(bus_i.wdata);
   endproperty
   a_load: assert property (p_load) else $error("high byte not loaded");
   property p_lock;
      !ewen_flag_o && hi_wr |=> $stable(flash_wdata_o);
   endproperty
   a_lock: assert property (p_lock) else $error("load while locked");
   property p_noset;
      !ewen_flag_o && c0_wr |=> !ewen_flag_o;
   endproperty
   a_noset: assert property (p_noset) else $error("flag set by software");
   property p_clr;
      ewen_flag_o && c0_wr && !bus_i.wdata[`FPWB_C0_EWEN] |=> !ewen_flag_o;
   endproperty
   a_clr: assert property (p_clr) else $error("flag not cleared");
   property p_modes;
      flash_cmd_o.req |-> flash_cmd_o.mode inside {`FPWB_MODE_WRITE, `FPWB_MODE_ERASE, `FPWB_MODE_READ};
   endproperty
   a_modes: assert property (p_modes) else $error("request in reserved mode");
   property p_ewreq;
      flash_cmd_o.req && flash_cmd_o.mode != `FPWB_MODE_READ |-> $past(ewen_flag_o);
   endproperty
   a_ewreq: assert property (p_ewreq) else $error("erase or write while disabled");
   property p_base;
      flash_cmd_o.req && flash_cmd_o.mode == `FPWB_MODE_ERASE |-> flash_cmd_o.addr[6:0] == 7'h00;
   endproperty
   a_base: assert property (p_base) else $error("erase not on page base");
   property p_pulse;
      flash_cmd_o.req |=> !flash_cmd_o.req;
   endproperty
   a_pulse: assert property (p_pulse) else $error("request longer than one cycle");
   c_wr: cover property (flash_cmd_o.req && flash_cmd_o.mode == `FPWB_MODE_WRITE);
   c_rd: cover property (flash_cmd_o.req && flash_cmd_o.mode == `FPWB_MODE_READ);
   c_ld: cover property (ewen_flag_o && hi_wr);
endmodule : fpwb_checker
bind fpwb_top fpwb_checker u_chk (
   .clk_sys_i(clk_sys_i),
   .rst_i(rst_i),
   .bus_i(bus_i),
   .flash_cmd_o(flash_cmd_o),
   .flash_wdata_o(flash_wdata_o),
   .ewen_flag_o(ewen_flag_o)
);

// ==== dv/fpwb_top_tb.sv ====
`timescale 1ns/1ps
module fpwb_top_tb;
   import fpwb_pkg::*;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   fpwb_bus_s bus_i = '0;
   logic flash_done_i = 1'b0;
   logic [15:0] flash_rdata_i = 16'h0000;
   logic [6:0] buf_raddr_i = 7'h00;
   logic [7:0] rdata_o;
   fpwb_flash_cmd_s flash_cmd_o;
   logic [15:0] flash_wdata_o;
   logic [15:0] buf_rdata_o;
   logic ewen_flag_o;
   int fail_count = 0;
   int checks = 0;
   always #4 clk_sys_i = ~clk_sys_i;
   // short unlock window keeps the timeout case cheap
   fpwb_top #(.ENABLE_WIN_CYC(16), .CLEAR_CYC(8)) dut (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .bus_i(bus_i),
      .rdata_o(rdata_o),
      .flash_cmd_o(flash_cmd_o),
      .flash_wdata_o(flash_wdata_o),
      .flash_done_i(flash_done_i),
      .flash_rdata_i(flash_rdata_i),
      .buf_raddr_i(buf_raddr_i),
      .buf_rdata_o(buf_rdata_o),
      .ewen_flag_o(ewen_flag_o)
   );
   // ------
   // bus tasks
   // ------
   task automatic report_and_stop();
      if (fail_count == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // idle cycle after each strobe so no signal is driven twice in one step
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      bus_i <= '{a, d, 1'b1, 1'b0};
      @(posedge clk_sys_i);
      bus_i <= '0;
      @(posedge clk_sys_i);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      bus_i <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk_sys_i);
      bus_i <= '0;
      @(negedge clk_sys_i);
      chk(rdata_o, e);
      @(posedge clk_sys_i);
   endtask : rd
   task automatic bchk(input logic [6:0] i, input logic [15:0] e);
      buf_raddr_i <= i;
      @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      chk(buf_rdata_o, e);
      @(posedge clk_sys_i);
   endtask : bchk
   task automatic go(input logic [7:0] d, input logic [12:0] e);
      int n;
      n = 0;
      bus_i <= '{4'h0, d, 1'b1, 1'b0};
      @(posedge clk_sys_i);
      bus_i <= '0;
      @(negedge clk_sys_i);
      while (flash_cmd_o.req !== 1'b1 && n < 20) begin
         @(negedge clk_sys_i);
         n++;
      end
      chk({flash_cmd_o.req, flash_cmd_o.req ? {flash_cmd_o.mode, flash_cmd_o.addr[15:7]} : 12'h000}, e);
      @(posedge clk_sys_i);
   endtask : go
   task automatic done(input logic [15:0] d);
      flash_rdata_i <= d;
      flash_done_i <= 1'b1;
      @(posedge clk_sys_i);
      flash_done_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask : done
   initial begin
      repeat (3000) @(posedge clk_sys_i);
      fail_count++;
      report_and_stop();
   end
   initial begin
      repeat (3) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      @(posedge clk_sys_i);
      rd(4'h0, 8'h00);
      rd(4'hD, 8'h00);
      wr(4'h0, 8'h80);
      rd(4'h0, 8'h00);
      wr(4'h5, 8'h34);
      wr(4'h6, 8'h12);
      rd(4'h3, 8'h00);
      bchk(7'h00, 16'h0000);
      wr(4'h0, 8'h68);
      rd(4'h0, 8'h68);
      repeat (20) @(posedge clk_sys_i);
      rd(4'h0, 8'h60);
      wr(4'h0, 8'h68);
      for (int i = 1; i < 4; i++) begin
         wr(4'(5 + 2 * i), 8'(i));
         wr(4'(6 + 2 * i), 8'h00);
      end
      rd(4'h0, 8'hE0);
      wr(4'h2, 8'h01);
      rd(4'h2, 8'h01);
      repeat (12) @(posedge clk_sys_i);
      rd(4'h2, 8'h00);
      wr(4'h4, 8'h03);
      wr(4'h3, 8'hFD);
      wr(4'h5, 8'h77);
      rd(4'h3, 8'hFD);
      for (int k = 0; k < 4; k++) begin
         wr(4'h5, 8'(k));
         wr(4'h6, 8'(8'hA0 + k));
      end
      rd(4'h3, 8'hFF);
      rd(4'h4, 8'h03);
      chk(flash_wdata_o, 16'hA303);
      bchk(7'h7D, 16'hA000);
      bchk(7'h7E, 16'hA101);
      bchk(7'h7F, 16'hA303);
      bchk(7'h7C, 16'h0000);
      // saturated: point back at the page base before erasing
      wr(4'h3, 8'h80);
      go(8'h94, {1'b1, 3'h1, 9'h007});
      done(16'h0000);
      rd(4'h0, 8'h90);
      go(8'h84, {1'b1, 3'h0, 9'h007});
      rd(4'h0, 8'h84);
      done(16'h0000);
      rd(4'h0, 8'h80);
      bchk(7'h7F, 16'h0000);
      bchk(7'h7D, 16'h0000);
      // bad verify: clear, then reload
      wr(4'h2, 8'h01);
      repeat (12) @(posedge clk_sys_i);
      wr(4'h5, 8'h11);
      wr(4'h6, 8'h22);
      bchk(7'h00, 16'h2211);
      rd(4'h3, 8'h81);
      for (int m = 2; m < 8; m++) begin
         if (m != 3) begin
            go(8'(8'h84 | (m << 4)), 13'h0000);
            rd(4'h0, 8'(8'h80 | (m << 4)));
         end
      end
      go(8'hB1, 13'h0000);
      rd(4'h0, 8'hB0);
      go(8'hB3, {1'b1, 3'h3, 9'h007});
      done(16'hBEEF);
      rd(4'h0, 8'hB2);
      rd(4'h5, 8'hEF);
      rd(4'h6, 8'hBE);
      wr(4'h0, 8'h00);
      @(negedge clk_sys_i);
      chk(ewen_flag_o, 1'b0);
      @(posedge clk_sys_i);
      wr(4'h6, 8'h55);
      rd(4'h3, 8'h81);
      bchk(7'h01, 16'h0000);
      report_and_stop();
   end
endmodule : fpwb_top_tb
